// ==== hdl/pin_select_pkg.sv ====
// constants for the remappable pin select crossbar
// assumes an APB slave port and a 10 MHz system clock
package pin_select_pkg;
    localparam int NUM_PINS = 26;                // remappable pins 0..25
    localparam int SEL_W = 5;                    // every selector field
    localparam int NUM_OUT = 4;                  // remappable pins 8..11
    localparam logic [SEL_W-1:0] SEL_MAX_PIN = 5'h19;   // highest routable pin
    localparam logic [SEL_W-1:0] SEL_GROUND = 5'h1F;    // tie input low
    localparam logic [SEL_W-1:0] RESET_IN_SEL = 5'h1F;  // inputs grounded at reset
    localparam logic [SEL_W-1:0] RESET_OUT_SEL = 5'h00; // outputs unassigned at reset
    localparam logic [SEL_W-1:0] FUNC_NONE = 5'h00;     // no peripheral
    localparam logic [SEL_W-1:0] FUNC_LAST = 5'h12;     // highest implemented function
    localparam int FUNC_W = 19;                  // width of function vector (FUNC_LAST+1)
    localparam int LO_LSB = 0;                   // low field lsb
    localparam int HI_LSB = 8;                   // high field lsb
    localparam int ADDR_W = 12;                  // decoded address bits
    localparam logic [ADDR_W-1:0] OFF_FAULT_MAP = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_UART2_MAP = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_OUT_8_9 = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_OUT_10_11 = 12'h00C;
    localparam logic [31:0] READ_ZERO = 32'h00000000;   // unmapped and idle read data
endpackage : pin_select_pkg

// ==== hdl/pin_sync_if.sv ====
// carrier between pin synchroniser and crossbar
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface pin_sync_if;
    logic [pin_select_pkg::NUM_PINS-1:0] raw;    // pin levels as they arrive
    logic [pin_select_pkg::NUM_PINS-1:0] level;  // filtered, clock-aligned levels
    modport sync (input raw, output level);
    modport user (output raw, input level);
endinterface : pin_sync_if

// ==== hdl/pin_input_sync.sv ====
// three-stage synchroniser with agreement filter per pin
// assumes pins are asynchronous to CLK
`timescale 1ns/10ps
module pin_input_sync (
    input wire logic CLK,
    input wire logic RST_N,
    pin_sync_if.sync pins
);
    // all synchroniser state
    typedef struct packed {
        logic [pin_select_pkg::NUM_PINS-1:0] s1;    // metastability catcher
        logic [pin_select_pkg::NUM_PINS-1:0] s2;    // second stage
        logic [pin_select_pkg::NUM_PINS-1:0] s3;    // third stage
        logic [pin_select_pkg::NUM_PINS-1:0] level; // accepted level
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    always_comb begin
        next_s = s;
        next_s.s1 = pins.raw;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        // where the two later stages agree take their level, elsewhere hold the old one
        next_s.level = (s.s2 & s.s3) | ((s.s2 ^ s.s3) & s.level);
    end

    // register the copy
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign pins.level = s.level;
endmodule : pin_input_sync

// ==== hdl/remappable_pin_select.sv ====
// peripheral pin select crossbar with APB register access
// assumes APB master on CLK; pins asynchronous; peripheral outputs on CLK
`timescale 1ns/10ps
module remappable_pin_select (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [pin_select_pkg::ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [pin_select_pkg::NUM_PINS-1:0] REMAPPABLE_PIN_IN,
    output logic COMPARE_FAULT_A_INPUT,
    output logic UART2_RECEIVE_INPUT,
    output logic UART2_CTS_INPUT,
    input wire logic [pin_select_pkg::FUNC_W-1:0] PERIPH_FUNCTION_OUT,
    output logic [pin_select_pkg::NUM_OUT-1:0] REMAPPABLE_PIN_OUT,
    output logic [pin_select_pkg::NUM_OUT-1:0] REMAPPABLE_PIN_OE
);
    localparam int W = pin_select_pkg::SEL_W;

    // whole block state, outputs included so every port is a flop
    typedef struct packed {
        logic [W-1:0] fault_sel;                       // compare_fault_a_select
        logic [W-1:0] rx_sel;                          // uart2_receive_select
        logic [W-1:0] cts_sel;                         // uart2_cts_select
        logic [pin_select_pkg::NUM_OUT-1:0][W-1:0] out_sel; // pin8..pin11 functions
        logic fault_in;                                // routed peripheral inputs
        logic rx_in;
        logic cts_in;
        logic [pin_select_pkg::NUM_OUT-1:0] pin_out;   // function level per pin
        logic [pin_select_pkg::NUM_OUT-1:0] pin_oe;    // peripheral owns pin
        logic [31:0] rdata;                            // apb read data
        logic ready;                                   // apb ready
        logic slverr;                                  // apb error
        logic wrote;                                   // any write to a mapped register seen, for checks
    } xbar_state_t;

    xbar_state_t s;
    xbar_state_t next_s;

    pin_sync_if pins ();

    // three-flop synchroniser for the remappable pins
    pin_input_sync pin_input_sync_i (
        .CLK(CLK),
        .RST_N(RST_N),
        .pins(pins.sync)
    );

    assign pins.raw = REMAPPABLE_PIN_IN;

    // pick a pin for a peripheral input
    function automatic logic route_in(input logic [W-1:0] sel, input logic [pin_select_pkg::NUM_PINS-1:0] lv);
        logic r;
        r = 1'b0;
        if (sel <= pin_select_pkg::SEL_MAX_PIN) begin
            r = lv[sel];
        end
        // all-ones and the unused codes 26..30 give ground
        return r;
    endfunction : route_in

    // two fields packed into a register image; gaps read zero
    function automatic logic [31:0] pack2(input logic [W-1:0] hi, input logic [W-1:0] lo);
        logic [31:0] v;
        v = pin_select_pkg::READ_ZERO;
        v[pin_select_pkg::HI_LSB +: W] = hi;
        v[pin_select_pkg::LO_LSB +: W] = lo;
        return v;
    endfunction : pack2

    // byte-lane update of one field
    function automatic logic [W-1:0] lane(input logic [W-1:0] old, input logic en, input logic [W-1:0] wd);
        return en ? wd : old;
    endfunction : lane

    // the fault map has no high field
    function automatic logic [W-1:0] empty_field();
        return pin_select_pkg::RESET_OUT_SEL;
    endfunction : empty_field

    logic setup;            // apb setup cycle
    logic wr_take;          // write completes this edge
    logic [W-1:0] wd_lo;    // write data, low field
    logic [W-1:0] wd_hi;    // write data, high field

    assign setup = PSEL && !PENABLE;
    assign wr_take = PSEL && PENABLE && PWRITE && s.ready && !s.slverr;
    assign wd_lo = PWDATA[pin_select_pkg::LO_LSB +: W];
    assign wd_hi = PWDATA[pin_select_pkg::HI_LSB +: W];

    // output side decode, one copy per remappable output pin
    logic [pin_select_pkg::NUM_OUT-1:0] func_valid; // selector names an implemented function
    logic [pin_select_pkg::NUM_OUT-1:0] func_level; // that function's level, low when released
    for (genvar k = 0; k < pin_select_pkg::NUM_OUT; k++) begin : g_out_pin
        assign func_valid[k] = (s.out_sel[k] != pin_select_pkg::FUNC_NONE)
            && (s.out_sel[k] <= pin_select_pkg::FUNC_LAST);
        // codes past the last function index beyond the vector; the valid term masks them
        assign func_level[k] = func_valid[k] && PERIPH_FUNCTION_OUT[s.out_sel[k]];
    end

    // next-state logic: apb slave, registers, crossbar
    always_comb begin
        next_s = s;
        // ready answers the setup cycle, so every access has no wait state
        next_s.ready = setup;
        next_s.slverr = 1'b0;
        next_s.rdata = pin_select_pkg::READ_ZERO;
        if (setup) begin
            case (PADDR)
                pin_select_pkg::OFF_FAULT_MAP: begin
                    next_s.rdata = pack2(empty_field(), s.fault_sel);
                end
                pin_select_pkg::OFF_UART2_MAP: begin
                    next_s.rdata = pack2(s.cts_sel, s.rx_sel);
                end
                pin_select_pkg::OFF_OUT_8_9: begin
                    next_s.rdata = pack2(s.out_sel[1], s.out_sel[0]);
                end
                pin_select_pkg::OFF_OUT_10_11: begin
                    next_s.rdata = pack2(s.out_sel[3], s.out_sel[2]);
                end
                default: begin
                    // unmapped: error, read zero
                    next_s.slverr = 1'b1;
                end
            endcase
        end
        // writes land only at the completing access edge
        if (wr_take) begin
            next_s.wrote = 1'b1;
            case (PADDR)
                pin_select_pkg::OFF_FAULT_MAP: begin
                    next_s.fault_sel = lane(s.fault_sel, PSTRB[0], wd_lo);
                end
                pin_select_pkg::OFF_UART2_MAP: begin
                    next_s.rx_sel = lane(s.rx_sel, PSTRB[0], wd_lo);
                    next_s.cts_sel = lane(s.cts_sel, PSTRB[1], wd_hi);
                end
                pin_select_pkg::OFF_OUT_8_9: begin
                    next_s.out_sel[0] = lane(s.out_sel[0], PSTRB[0], wd_lo);
                    next_s.out_sel[1] = lane(s.out_sel[1], PSTRB[1], wd_hi);
                end
                pin_select_pkg::OFF_OUT_10_11: begin
                    next_s.out_sel[2] = lane(s.out_sel[2], PSTRB[0], wd_lo);
                    next_s.out_sel[3] = lane(s.out_sel[3], PSTRB[1], wd_hi);
                end
                default: begin
                    next_s.wrote = s.wrote;
                end
            endcase
        end
        // input side of the crossbar
        next_s.fault_in = route_in(s.fault_sel, pins.level);
        next_s.rx_in = route_in(s.rx_sel, pins.level);
        next_s.cts_in = route_in(s.cts_sel, pins.level);
        // output side: codes naming no function release the pin to port logic
        next_s.pin_oe = func_valid;
        next_s.pin_out = func_level;
    end

    // state register; inputs grounded, outputs unassigned after reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s <= '0;
            s.fault_sel <= pin_select_pkg::RESET_IN_SEL;
            s.rx_sel <= pin_select_pkg::RESET_IN_SEL;
            s.cts_sel <= pin_select_pkg::RESET_IN_SEL;
            s.out_sel <= {pin_select_pkg::NUM_OUT{pin_select_pkg::RESET_OUT_SEL}};
        end else begin
            s <= next_s;
        end
    end

    // ports straight from flops
    assign PRDATA = s.rdata;
    assign PREADY = s.ready;
    assign PSLVERR = s.slverr;
    assign COMPARE_FAULT_A_INPUT = s.fault_in;
    assign UART2_RECEIVE_INPUT = s.rx_in;
    assign UART2_CTS_INPUT = s.cts_in;
    assign REMAPPABLE_PIN_OUT = s.pin_out;
    assign REMAPPABLE_PIN_OE = s.pin_oe;

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_pin_route: assert property (
        (s.fault_sel <= pin_select_pkg::SEL_MAX_PIN) |=> (COMPARE_FAULT_A_INPUT == $past(pins.level[s.fault_sel])))
        else $error("fault input not routed from selected pin");

    a_ground_tie: assert property (
        (s.rx_sel == pin_select_pkg::SEL_GROUND) |=> !UART2_RECEIVE_INPUT)
        else $error("grounded receive input not low");

    a_reset_ones: assert property (
        !s.wrote |-> (s.fault_sel == pin_select_pkg::RESET_IN_SEL && s.rx_sel == pin_select_pkg::RESET_IN_SEL
            && s.cts_sel == pin_select_pkg::RESET_IN_SEL))
        else $error("input selector lost reset value");

    a_fault_read: assert property (
        (setup && !PWRITE && PADDR == pin_select_pkg::OFF_FAULT_MAP) |=> PREADY
            && PRDATA == {27'h0000000, $past(s.fault_sel)})
        else $error("fault map read wrong");

    a_uart_write: assert property (
        (wr_take && PADDR == pin_select_pkg::OFF_UART2_MAP && PSTRB == 4'hF) |=> (s.rx_sel == $past(wd_lo)
            && s.cts_sel == $past(wd_hi)))
        else $error("uart map write not stored");

    a_uart_gaps: assert property (
        (setup && PADDR == pin_select_pkg::OFF_UART2_MAP) |=> (PRDATA[7:5] == 3'h0 && PRDATA[31:13] == 19'h00000))
        else $error("uart map gap bits not zero");

    a_out_write: assert property (
        (wr_take && PADDR == pin_select_pkg::OFF_OUT_10_11 && PSTRB == 4'hF) |=> (s.out_sel[3] == $past(wd_hi)
            && s.out_sel[2] == $past(wd_lo)))
        else $error("second output map write not stored");

    a_out_reset: assert property (
        !s.wrote |-> (REMAPPABLE_PIN_OE == 4'h0 && s.out_sel == '0))
        else $error("output map not zero after reset");

    a_out_drive: assert property (
        (s.out_sel[1] != pin_select_pkg::FUNC_NONE && s.out_sel[1] <= pin_select_pkg::FUNC_LAST)
            |=> REMAPPABLE_PIN_OE[1] && REMAPPABLE_PIN_OUT[1] == $past(PERIPH_FUNCTION_OUT[s.out_sel[1]]))
        else $error("pin 9 not driven by selected function");

    a_out_release: assert property (
        (s.out_sel[0] == pin_select_pkg::FUNC_NONE || s.out_sel[0] > pin_select_pkg::FUNC_LAST)
            |=> !REMAPPABLE_PIN_OE[0])
        else $error("pin 8 driven with no function");

    // input side: every peripheral input follows its own selector
    a_rx_route: assert property (
        (s.rx_sel <= pin_select_pkg::SEL_MAX_PIN) |=> (UART2_RECEIVE_INPUT == $past(pins.level[s.rx_sel])))
        else $error("receive input not routed from selected pin");

    a_cts_route: assert property (
        (s.cts_sel <= pin_select_pkg::SEL_MAX_PIN) |=> (UART2_CTS_INPUT == $past(pins.level[s.cts_sel])))
        else $error("clear-to-send input not routed from selected pin");

    a_fault_ground: assert property (
        (s.fault_sel > pin_select_pkg::SEL_MAX_PIN) |=> !COMPARE_FAULT_A_INPUT)
        else $error("grounded fault input not low");

    a_cts_ground: assert property (
        (s.cts_sel > pin_select_pkg::SEL_MAX_PIN) |=> !UART2_CTS_INPUT)
        else $error("grounded clear-to-send input not low");

    // register side: reads show the stored fields, gaps read zero
    a_fault_gaps: assert property (
        (setup && PADDR == pin_select_pkg::OFF_FAULT_MAP) |=> (PRDATA[31:5] == 27'h0000000))
        else $error("fault map gap bits not zero");

    a_fault_write: assert property (
        (wr_take && PADDR == pin_select_pkg::OFF_FAULT_MAP && PSTRB[0]) |=> (s.fault_sel == $past(wd_lo)))
        else $error("fault map write not stored");

    a_uart_read: assert property (
        (setup && !PWRITE && PADDR == pin_select_pkg::OFF_UART2_MAP) |=> PREADY
            && PRDATA == {19'h00000, $past(s.cts_sel), 3'h0, $past(s.rx_sel)})
        else $error("uart map read wrong");

    a_first_map_write: assert property (
        (wr_take && PADDR == pin_select_pkg::OFF_OUT_8_9 && PSTRB[1:0] == 2'h3) |=> (s.out_sel[1] == $past(wd_hi)
            && s.out_sel[0] == $past(wd_lo)))
        else $error("first output map write not stored");

    a_map_read: assert property (
        (setup && !PWRITE && PADDR == pin_select_pkg::OFF_OUT_8_9) |=> PREADY
            && PRDATA == {19'h00000, $past(s.out_sel[1]), 3'h0, $past(s.out_sel[0])})
        else $error("first output map read wrong");

    a_map_gaps: assert property (
        (setup && (PADDR == pin_select_pkg::OFF_OUT_8_9 || PADDR == pin_select_pkg::OFF_OUT_10_11))
            |=> (PRDATA[7:5] == 3'h0 && PRDATA[31:13] == 19'h00000))
        else $error("output map gap bits not zero");

    a_bad_addr: assert property (
        (setup && PADDR != pin_select_pkg::OFF_FAULT_MAP && PADDR != pin_select_pkg::OFF_UART2_MAP
            && PADDR != pin_select_pkg::OFF_OUT_8_9 && PADDR != pin_select_pkg::OFF_OUT_10_11)
            |=> (PREADY && PSLVERR && PRDATA == pin_select_pkg::READ_ZERO))
        else $error("unmapped access not refused");

    a_ready_pulse: assert property (
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    // output side: the upper pins follow the same decode
    a_pin11_drive: assert property (
        (s.out_sel[3] != pin_select_pkg::FUNC_NONE && s.out_sel[3] <= pin_select_pkg::FUNC_LAST)
            |=> REMAPPABLE_PIN_OE[3] && REMAPPABLE_PIN_OUT[3] == $past(PERIPH_FUNCTION_OUT[s.out_sel[3]]))
        else $error("pin 11 not driven by selected function");

    a_pin10_release: assert property (
        (s.out_sel[2] == pin_select_pkg::FUNC_NONE || s.out_sel[2] > pin_select_pkg::FUNC_LAST)
            |=> (!REMAPPABLE_PIN_OE[2] && !REMAPPABLE_PIN_OUT[2]))
        else $error("pin 10 driven with no function");

    c_pin_driven: cover property (REMAPPABLE_PIN_OE[3]);
    c_rx_routed: cover property (s.rx_sel <= pin_select_pkg::SEL_MAX_PIN ##1 UART2_RECEIVE_INPUT);
    c_bad_addr: cover property (PREADY && PSLVERR);
    c_cts_routed: cover property (s.cts_sel <= pin_select_pkg::SEL_MAX_PIN ##1 UART2_CTS_INPUT);
    c_write_done: cover property (wr_take);
endmodule : remappable_pin_select

// ==== tb/pin_world_model.sv ====
// far side of the crossbar: remappable package pins and peripheral output functions
// assumes the bench sets target levels; the model launches them just after a CLK edge
`timescale 1ns/10ps
module pin_world_model (
    input wire logic clk,
    input wire logic [pin_select_pkg::NUM_PINS-1:0] pin_target,
    input wire logic [pin_select_pkg::FUNC_W-1:0] func_target,
    output logic [pin_select_pkg::NUM_PINS-1:0] pin_level,
    output logic [pin_select_pkg::FUNC_W-1:0] func_level
);
    // pins and peripherals change after an edge, never on it
    always @(posedge clk) begin
        pin_level <= pin_target;
        func_level <= func_target;
    end
endmodule : pin_world_model

// ==== tb/remappable_pin_select_test.sv ====
// self-checking bench for the pin select crossbar, registers over APB
// waits on pready for each APB access and assumes a few cycles of input synchroniser latency
`timescale 1ns/10ps
module remappable_pin_select_test;
    logic clk = 1'b0; // 10 MHz system clock
    logic rst_n = 1'b0; // active low reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, err;
    logic [25:0] pin_target = 26'h0000000, pin_level;
    logic [18:0] func_target = 19'h00000, func_level;
    logic fault_in, rx_in, cts_in;
    logic [3:0] pin_out, pin_oe;
    int num_errors = 0, check_count = 0, cycles = 0;
    logic [3:0] pstrb = 4'hF; // byte lanes of the next write
    logic [4:0] m5 [3] = '{5'h00, 5'h13, 5'h1F}; // unassigned output codes
    localparam logic [11:0] FLT = pin_select_pkg::OFF_FAULT_MAP, UAR = pin_select_pkg::OFF_UART2_MAP;
    localparam logic [11:0] O89 = pin_select_pkg::OFF_OUT_8_9, O1011 = pin_select_pkg::OFF_OUT_10_11;

    always #50 clk = ~clk;
    remappable_pin_select remappable_pin_select_i (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .REMAPPABLE_PIN_IN(pin_level), .COMPARE_FAULT_A_INPUT(fault_in),
        .UART2_RECEIVE_INPUT(rx_in), .UART2_CTS_INPUT(cts_in), .PERIPH_FUNCTION_OUT(func_level),
        .REMAPPABLE_PIN_OUT(pin_out), .REMAPPABLE_PIN_OE(pin_oe));
    pin_world_model pin_world_model_i (.clk(clk), .pin_target(pin_target), .func_target(func_target),
        .pin_level(pin_level), .func_level(func_level));

    // hang guard: whole run is well under this many cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no assumed wait: only the hang guard ends a stuck access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rdchk

    // synchroniser plus output register, with margin
    task automatic settle();
        repeat (8) @(posedge clk);
    endtask : settle

    function automatic logic [31:0] ins();
        return {29'h0, fault_in, rx_in, cts_in};
    endfunction : ins

    function automatic logic [31:0] pair(input logic [4:0] hi, input logic [4:0] lo);
        return {19'h0, hi, 3'h0, lo};
    endfunction : pair

    initial begin
        logic [4:0] m;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        // reset state: inputs grounded even with every pin high
        pin_target <= '1;
        settle();
        chk(ins(), 32'h0);
        rdchk(FLT, 32'h0000001F);
        rdchk(UAR, 32'h00001F1F);
        rdchk(O89, 32'h0);
        rdchk(O1011, 32'h0);
        chk({24'h0, pin_oe, pin_out}, 32'h0);
        $display("test reset done");
        // unimplemented bits read zero after writing all ones
        apb(1'b1, FLT, 32'hFFFFFFFF);
        apb(1'b1, UAR, 32'hFFFFFFFF);
        apb(1'b1, O89, 32'hFFFFFFFF);
        apb(1'b1, O1011, 32'hFFFFFFFF);
        rdchk(FLT, 32'h0000001F);
        rdchk(UAR, 32'h00001F1F);
        rdchk(O89, 32'h00001F1F);
        rdchk(O1011, 32'h00001F1F);
        rdchk(12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test masks done");
        // every pin code; cts on the next pin keeps the fields apart
        for (int n = 0; n < 26; n++) begin
            m = (n == 25) ? 5'h00 : 5'(n + 1);
            apb(1'b1, UAR, pair(m, 5'(n)));
            apb(1'b1, FLT, {27'h0, 5'(n)});
            pin_target <= 26'h1 << n;
            settle();
            chk(ins(), 32'h6);
            pin_target <= ~(26'h1 << n);
            settle();
            chk(ins(), 32'h1);
        end
        // ground codes with all pins high
        pin_target <= '1;
        for (int c = 26; c < 32; c++) begin
            apb(1'b1, UAR, pair(5'(c), 5'(c)));
            apb(1'b1, FLT, {27'h0, 5'(c)});
            settle();
            chk(ins(), 32'h0);
        end
        $display("test input routing done");
        // byte strobes: each lane writes only its own field
        pstrb <= 4'h1;
        apb(1'b1, UAR, pair(5'h05, 5'h06));
        rdchk(UAR, 32'h00001F06);
        pstrb <= 4'h2;
        apb(1'b1, UAR, pair(5'h07, 5'h08));
        pstrb <= 4'hF;
        rdchk(UAR, 32'h00000706);
        $display("test byte lanes done");
        // every implemented output function on all four pins
        for (int f = 1; f < 19; f++) begin
            apb(1'b1, O89, pair(5'(f), 5'(f)));
            apb(1'b1, O1011, pair(5'(f), 5'(f)));
            func_target <= 19'h1 << f;
            settle();
            chk({24'h0, pin_oe, pin_out}, 32'hFF);
            func_target <= ~(19'h1 << f);
            settle();
            chk({24'h0, pin_oe, pin_out}, 32'hF0);
        end
        // distinct functions show which field feeds which pin
        apb(1'b1, O89, pair(5'h02, 5'h01));
        apb(1'b1, O1011, pair(5'h04, 5'h03));
        func_target <= 19'h00008;
        settle();
        chk({24'h0, pin_oe, pin_out}, 32'hF4);
        // codes naming no function release the pins
        func_target <= '1;
        foreach (m5[i]) begin
            apb(1'b1, O89, pair(m5[i], m5[i]));
            apb(1'b1, O1011, pair(m5[i], m5[i]));
            settle();
            chk({24'h0, pin_oe, pin_out}, 32'h0);
        end
        $display("test output mapping done");
        // reset in mid-run restores the fault, uart and pin 8/9 selectors after writes
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        rdchk(FLT, 32'h0000001F);
        rdchk(UAR, 32'h00001F1F);
        rdchk(O89, 32'h0);
        chk({24'h0, pin_oe, pin_out}, 32'h0);
        $display("test reset again done");
        stop_test();
    end
endmodule : remappable_pin_select_test
